// >>> verif/sof_asserts.sv
`timescale 1ns/1ps
// ==========================
// Port checker
module sof_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] wb_adr_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	input wire logic vs_pin_i,
	input logic vert_sync_out,
	input logic vert_sync_oe,
	input logic regen_hsync_out,
	input logic addr_lsb_strap
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 32'h84
		|-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_oe_late: assert property ($fell(rst) |-> !vert_sync_oe ##1 !vert_sync_oe)
		else $error("pin driven during strap");
	a_oe_rises: assert property ($fell(rst) |-> ##[1:12] vert_sync_oe)
		else $error("pin never driven");
	a_idle_high: assert property ($fell(rst) |=> regen_hsync_out && vert_sync_out)
		else $error("sync outputs not idle");
	a_strap_hold: assert property (vert_sync_oe && $past(vert_sync_oe)
		|-> $stable(addr_lsb_strap))
		else $error("strap changed in run");
	a_strap_pin: assert property ($rose(vert_sync_oe)
		|-> addr_lsb_strap == $past(vs_pin_i, 3))
		else $error("strap not pin level");
endmodule : sof_asserts

// >>> verif/sof_pin_model.sv
`timescale 1ns/1ps
// ==========================
// Shared vsync/strap pin
module sof_pin_model #(parameter logic PULL = 1'h1) (
	input wire logic vert_sync_out,
	input wire logic vert_sync_oe,
	output logic vs_pin_i
);
	// Released pin rests at the pull-up level
	assign vs_pin_i = vert_sync_oe ? vert_sync_out : PULL;
endmodule : sof_pin_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk, rst, we, cyc, stb, hs_in, vs_in, gs_in, fh_in, vs_pin;
	logic [31:0] adr, wdat, rdat, wb_dat_o;
	logic [3:0] sel;
	logic wb_ack_o, vert_sync_out, vert_sync_oe, regen_hsync_out;
	logic green_sync_slicer_out, odd_even_field_out, coast_out, addr_lsb_strap;
	integer bad_count, total_checks;
	logic [1:0] code_tab [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
	sof_sync_output_formatter i_dut (.clk(clk), .rst(rst), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.horiz_sync_input(hs_in), .vert_sync_input(vs_in),
		.green_sync_input(gs_in), .filtered_hsync_input(fh_in),
		.vs_pin_i(vs_pin), .vert_sync_out(vert_sync_out),
		.vert_sync_oe(vert_sync_oe), .regen_hsync_out(regen_hsync_out),
		.green_sync_slicer_out(green_sync_slicer_out),
		.odd_even_field_out(odd_even_field_out), .coast_out(coast_out),
		.addr_lsb_strap(addr_lsb_strap));
	sof_pin_model i_pin (.vert_sync_out(vert_sync_out),
		.vert_sync_oe(vert_sync_oe), .vs_pin_i(vs_pin));
	// ==========================
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Ack is read as it stood at the edge, before the edge's updates land
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		adr <= {24'h0, a};
		wdat <= d;
		we <= w;
		cyc <= 1'h1;
		stb <= 1'h1;
		@(posedge clk);
		// Only the watchdog ends a wait for ack
		while (wb_ack_o !== 1'h1) begin
			@(posedge clk);
		end
		rdat = wb_dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk);
	endtask : wb
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	// ==========================
	// Stimulus
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		bad_count++;
		test_done;
	end
	initial begin
		{rst, we, cyc, stb, hs_in, vs_in, gs_in, fh_in} = 8'h80;
		{adr, wdat} = 64'h0;
		sel = 4'hF;
		bad_count = 0;
		total_checks = 0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		repeat (12) @(posedge clk);
		chk({31'h0, addr_lsb_strap}, 32'h1);
		chk({31'h0, vert_sync_oe}, 32'h1);
		wb(sof_pkg::ADDR_VS_DUR, 1'h0, 32'h0);
		chk(rdat, {24'h0, sof_pkg::VS_DUR_RST});
		wb(sof_pkg::ADDR_HS_WIDTH, 1'h0, 32'h0);
		chk(rdat, {24'h0, sof_pkg::HS_WIDTH_RST});
		wb(8'hF0, 1'h0, 32'h0);
		chk(rdat, 32'h0);
		wb(sof_pkg::ADDR_VS_DUR, 1'h1, 32'h9A);
		wb(sof_pkg::ADDR_VS_DUR, 1'h0, 32'h0);
		chk(rdat, 32'h9A);
		// Hsync rises for raw and regenerated codes; pulse lasts 0x20 clocks
		for (int i = 0; i < 4; i++) begin
			wb(sof_pkg::ADDR_SLICER, 1'h1, {30'h0, code_tab[i]});
			gs_in <= code_tab[i] == 2'h0;
			hs_in <= code_tab[i][1] ^ code_tab[i][0];
			fh_in <= code_tab[i] == 2'h3;
			repeat (10) @(posedge clk);
			chk({31'h0, green_sync_slicer_out}, 32'h1);
			chk({31'h0, regen_hsync_out},
				{31'h0, code_tab[i][1] == code_tab[i][0]});
			{gs_in, hs_in, fh_in} <= 3'h0;
			repeat (60) @(posedge clk);
			chk({31'h0, green_sync_slicer_out}, 32'h0);
			chk({31'h0, regen_hsync_out}, 32'h1);
		end
		wb(sof_pkg::ADDR_VS_CTRL, 1'h1, 32'h31);
		vs_in <= 1'h1;
		repeat (10) @(posedge clk);
		chk({31'h0, vert_sync_out}, 32'h1);
		chk({31'h0, coast_out}, 32'h1);
		chk({31'h0, odd_even_field_out}, 32'h0);
		vs_in <= 1'h0;
		hs_in <= 1'h1;
		repeat (10) @(posedge clk);
		chk({31'h0, vert_sync_out}, 32'h0);
		// One line between two vsync edges gives an odd field
		{vs_in, hs_in} <= 2'h2;
		repeat (10) @(posedge clk);
		chk({31'h0, odd_even_field_out}, 32'h1);
		vs_in <= 1'h0;
		// Override: 0x9A clocks of vsync from a 10 clock source pulse
		wb(sof_pkg::ADDR_VS_CTRL, 1'h1, 32'h33);
		vs_in <= 1'h1;
		repeat (10) @(posedge clk);
		vs_in <= 1'h0;
		repeat (50) @(posedge clk);
		chk({31'h0, coast_out}, 32'h1);
		chk({31'h0, vert_sync_out}, 32'h1);
		repeat (140) @(posedge clk);
		chk({31'h0, coast_out}, 32'h0);
		// Separated source: green high plus an hsync edge clears it
		{gs_in, hs_in} <= 2'h3;
		wb(sof_pkg::ADDR_VS_CTRL, 1'h1, 32'h35);
		repeat (10) @(posedge clk);
		chk({31'h0, vert_sync_out}, 32'h0);
		gs_in <= 1'h0;
		repeat (100) @(posedge clk);
		chk({31'h0, vert_sync_out}, 32'h1);
		// Manual polarity 0: falling hsync edge leads, output active high
		wb(sof_pkg::ADDR_HS_CTRL, 1'h1, 32'h21);
		hs_in <= 1'h0;
		repeat (10) @(posedge clk);
		chk({31'h0, regen_hsync_out}, 32'h1);
		wb(sof_pkg::ADDR_VS_CTRL, 1'h1, 32'h30);
		repeat (6) @(posedge clk);
		chk({31'h0, vert_sync_out}, 32'h1);
		test_done;
	end
endmodule : tb_top
bind sof_sync_output_formatter sof_asserts i_chk (.*);

// >>> verilog/sof_pkg.sv
package sof_pkg;
	// ==========================================
	// Register byte addresses (Wishbone, 32-bit words)
	localparam logic [7:0] ADDR_HS_CTRL = 8'h48; // index 0x12
	localparam logic [7:0] ADDR_VS_CTRL = 8'h50; // index 0x14
	localparam logic [7:0] ADDR_VS_DUR = 8'h54; // index 0x15
	localparam logic [7:0] ADDR_SLICER = 8'h74; // index 0x1D
	localparam logic [7:0] ADDR_HS_WIDTH = 8'h80;
	localparam logic [7:0] ADDR_STATUS = 8'h84;
	// ==========================================
	// Field positions
	localparam int HS_POL_LO = 4; // 0x12 bits 5:4
	localparam int HS_OUTPOL_BIT = 0;
	localparam int VS_DUR_OVR_BIT = 1; // 0x14 bit 1
	localparam int VS_OUTPOL_BIT = 0;
	localparam int VS_SEP_BIT = 2;
	localparam int VS_POL_LO = 4; // 0x14 bits 5:4
	// ==========================================
	// Reset values
	localparam logic [7:0] HS_CTRL_RST = 8'h00;
	localparam logic [7:0] VS_CTRL_RST = 8'h00;
	localparam logic [7:0] VS_DUR_RST = 8'h04;
	localparam logic [1:0] SLICER_RST = 2'h0;
	localparam logic [7:0] HS_WIDTH_RST = 8'h20;
	// Slicer source codes
	localparam logic [1:0] SLC_RAW_GREEN = 2'h0;
	localparam logic [1:0] SLC_RAW_HSYNC = 2'h1;
	localparam logic [1:0] SLC_REGEN = 2'h2;
	localparam logic [1:0] SLC_FILTERED = 2'h3;
	// Separator: sync low longer than this many clocks counts as vertical
	localparam logic [7:0] SEP_LONG_CYC = 8'h40;
	localparam int STRAP_WAIT = 4;
	typedef enum logic [1:0] {
		ST_STRAP,
		ST_RUN
	} sof_mode_t;
endpackage : sof_pkg

// >>> verilog/sof_sync_output_formatter.sv
`timescale 1ns/1ps
module sof_sync_output_formatter (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic horiz_sync_input,
	input wire logic vert_sync_input,
	input wire logic green_sync_input,
	input wire logic filtered_hsync_input,
	input wire logic vs_pin_i,
	output logic vert_sync_out,
	output logic vert_sync_oe,
	output logic regen_hsync_out,
	output logic green_sync_slicer_out,
	output logic odd_even_field_out,
	output logic coast_out,
	output logic addr_lsb_strap
);
	typedef struct packed {
		logic [2:0] hs_s;
		logic [2:0] vs_s;
		logic [1:0] gs_s;
		logic [1:0] fh_s;
		logic [1:0] pin_s;
		logic [7:0] hs_ctrl;
		logic [7:0] vs_ctrl;
		logic [7:0] vs_dur;
		logic [1:0] slicer;
		logic [7:0] hs_width;
		sof_pkg::sof_mode_t mode;
		logic [2:0] strap_cnt;
		logic strap;
		logic [7:0] hs_cnt;
		logic hs_act;
		logic [7:0] vs_cnt;
		logic vs_act;
		logic [7:0] low_cnt;
		logic sep_vs;
		logic [15:0] line_cnt;
		logic field;
		logic vs_pol_auto;
		logic [31:0] dat;
		logic ack;
		logic vs_o;
		logic hs_o;
		logic sl_o;
		logic oe;
	} sof_state_t;
	sof_state_t s_reg, s_next;

	function automatic logic pol_sel(input logic [1:0] fld, input logic auto_v);
		// Bit 1 set: manual, bit 0 gives sense; else auto_v (detected for vsync, fixed 1 for hsync)
		pol_sel = fld[1] ? fld[0] : auto_v;
	endfunction : pol_sel

	logic hs_pol, vs_pol, hs_lead, vs_raw, vs_prev, vs_lead, vs_src, vs_src_p;
	logic wr, rd;

	always_comb begin
		s_next = s_reg;
		// Write lands on the edge that sees ack high, as a classic master expects
		wr = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack && wb_sel_i[0];
		rd = wb_cyc_i && wb_stb_i && !s_reg.ack;
		// ==========================================
		// Input synchronisers, first stage read only by the second
		s_next.hs_s = {s_reg.hs_s[1:0], horiz_sync_input};
		s_next.vs_s = {s_reg.vs_s[1:0], vert_sync_input};
		s_next.gs_s = {s_reg.gs_s[0], green_sync_input};
		s_next.fh_s = {s_reg.fh_s[0], filtered_hsync_input};
		s_next.pin_s = {s_reg.pin_s[0], vs_pin_i};
		// ==========================================
		// Strap capture: pin not driven until it is read
		s_next.mode = s_reg.mode;
		case (s_reg.mode)
		sof_pkg::ST_STRAP: begin
			if (s_reg.strap_cnt == 3'(sof_pkg::STRAP_WAIT)) begin
				s_next.strap = s_reg.pin_s[1];
				s_next.mode = sof_pkg::ST_RUN;
			end else begin
				s_next.strap_cnt = s_reg.strap_cnt + 3'h1;
			end
		end
		sof_pkg::ST_RUN: s_next.mode = sof_pkg::ST_RUN;
		default: s_next.mode = sof_pkg::ST_STRAP;
		endcase
		// Driver held off during strap so the pull-up level is read
		s_next.oe = (s_next.mode == sof_pkg::ST_RUN);
		// ==========================================
		// Horizontal: leading edge per polarity
		hs_pol = pol_sel(s_reg.hs_ctrl[sof_pkg::HS_POL_LO +: 2], 1'b1);
		hs_lead = hs_pol ? (s_reg.hs_s[1] && !s_reg.hs_s[2])
			: (!s_reg.hs_s[1] && s_reg.hs_s[2]);
		if (hs_lead) begin
			s_next.hs_act = 1'b1;
			s_next.hs_cnt = s_reg.hs_width;
			s_next.line_cnt = s_reg.line_cnt + 16'h1;
		end else if (s_reg.hs_act) begin
			if (s_reg.hs_cnt <= 8'h01) begin
				s_next.hs_act = 1'b0;
			end
			s_next.hs_cnt = s_reg.hs_cnt - 8'h01;
		end
		s_next.hs_o = s_reg.hs_act ^ !s_reg.hs_ctrl[sof_pkg::HS_OUTPOL_BIT];
		// ==========================================
		// Vertical: auto polarity from idle level, sampled at hsync edges
		if (hs_lead) begin
			s_next.vs_pol_auto = !s_reg.vs_s[1];
		end
		vs_pol = pol_sel(s_reg.vs_ctrl[sof_pkg::VS_POL_LO +: 2],
			s_reg.vs_pol_auto);
		// Composite separator on raw green sync: long low marks vsync
		if (!s_reg.gs_s[1]) begin
			if (s_reg.low_cnt != 8'hFF) begin
				s_next.low_cnt = s_reg.low_cnt + 8'h01;
			end
			if (s_reg.low_cnt >= sof_pkg::SEP_LONG_CYC) begin
				s_next.sep_vs = 1'b1;
			end
		end else begin
			s_next.low_cnt = 8'h00;
			if (hs_lead) begin
				s_next.sep_vs = 1'b0;
			end
		end
		vs_raw = vs_pol ? s_reg.vs_s[1] : !s_reg.vs_s[1];
		vs_prev = vs_pol ? s_reg.vs_s[2] : !s_reg.vs_s[2];
		vs_src = s_reg.vs_ctrl[sof_pkg::VS_SEP_BIT] ? s_reg.sep_vs : vs_raw;
		vs_src_p = s_reg.vs_act;
		vs_lead = vs_raw && !vs_prev;
		// Field: line parity at each vsync leading edge
		if (vs_lead) begin
			s_next.field = s_reg.line_cnt[0];
			s_next.line_cnt = 16'h0;
		end
		// Duration override
		if (s_reg.vs_ctrl[sof_pkg::VS_DUR_OVR_BIT]) begin
			if (vs_src && !s_reg.vs_act && s_reg.vs_cnt == 8'h00) begin
				s_next.vs_act = 1'b1;
				s_next.vs_cnt = s_reg.vs_dur;
			end else if (s_reg.vs_act) begin
				if (s_reg.vs_cnt <= 8'h01) begin
					s_next.vs_act = 1'b0;
				end
				s_next.vs_cnt = s_reg.vs_cnt - 8'h01;
			end else if (!vs_src) begin
				s_next.vs_cnt = 8'h00;
			end
		end else begin
			s_next.vs_act = vs_src;
			s_next.vs_cnt = 8'h00;
		end
		s_next.vs_o = vs_src_p ^ !s_reg.vs_ctrl[sof_pkg::VS_OUTPOL_BIT];
		// ==========================================
		// Slicer mux only, no other shaping
		case (s_reg.slicer)
		sof_pkg::SLC_RAW_GREEN: s_next.sl_o = s_reg.gs_s[1];
		sof_pkg::SLC_RAW_HSYNC: s_next.sl_o = s_reg.hs_s[1];
		sof_pkg::SLC_REGEN: s_next.sl_o = s_reg.hs_act;
		sof_pkg::SLC_FILTERED: s_next.sl_o = s_reg.fh_s[1];
		default: s_next.sl_o = s_reg.gs_s[1];
		endcase
		// ==========================================
		// Wishbone slave, one registered ack per request, one cycle after the strobe
		s_next.ack = rd;
		if (wr) begin
			case (wb_adr_i[7:0])
			sof_pkg::ADDR_HS_CTRL: s_next.hs_ctrl = wb_dat_i[7:0];
			sof_pkg::ADDR_VS_CTRL: s_next.vs_ctrl = wb_dat_i[7:0];
			sof_pkg::ADDR_VS_DUR: s_next.vs_dur = wb_dat_i[7:0];
			sof_pkg::ADDR_SLICER: s_next.slicer = wb_dat_i[1:0];
			sof_pkg::ADDR_HS_WIDTH: s_next.hs_width = wb_dat_i[7:0];
			default: s_next.ack = rd;
			endcase
		end
		s_next.dat = 32'h0;
		if (rd && !wb_we_i && wb_adr_i[31:8] == 24'h0) begin
			case (wb_adr_i[7:0])
			sof_pkg::ADDR_HS_CTRL: s_next.dat = {24'h0, s_reg.hs_ctrl};
			sof_pkg::ADDR_VS_CTRL: s_next.dat = {24'h0, s_reg.vs_ctrl};
			sof_pkg::ADDR_VS_DUR: s_next.dat = {24'h0, s_reg.vs_dur};
			sof_pkg::ADDR_SLICER: s_next.dat = {30'h0, s_reg.slicer};
			sof_pkg::ADDR_HS_WIDTH: s_next.dat = {24'h0, s_reg.hs_width};
			sof_pkg::ADDR_STATUS: s_next.dat = {28'h0, vs_pol, hs_pol,
				s_reg.field, s_reg.strap};
			default: s_next.dat = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.hs_ctrl <= sof_pkg::HS_CTRL_RST;
			s_reg.vs_ctrl <= sof_pkg::VS_CTRL_RST;
			s_reg.vs_dur <= sof_pkg::VS_DUR_RST;
			s_reg.slicer <= sof_pkg::SLICER_RST;
			s_reg.hs_width <= sof_pkg::HS_WIDTH_RST;
			s_reg.mode <= sof_pkg::ST_STRAP;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_dat_o = s_reg.dat;
	assign wb_ack_o = s_reg.ack;
	assign vert_sync_out = s_reg.vs_o;
	assign vert_sync_oe = s_reg.oe;
	assign regen_hsync_out = s_reg.hs_o;
	assign green_sync_slicer_out = s_reg.sl_o;
	assign odd_even_field_out = s_reg.field;
	assign coast_out = s_reg.vs_act;
	assign addr_lsb_strap = s_reg.strap;
endmodule : sof_sync_output_formatter
